// *** core/pwe_regs.svh ***
`ifndef PWE_REGS_SVH
`define PWE_REGS_SVH

// ==============================
// Device register offsets
`define PWE_OFF_INT_EN_CTL 8'hc4
`define PWE_OFF_IRQ_STS 8'hc8
`define PWE_OFF_PM_CTL 8'he0
`define PWE_OFF_PCI_PMCTL 8'h44
`define PWE_OFF_PHY_CFG 8'h50

// ==============================
// Field positions
`define PWE_B_SOFT_IRQ 15
`define PWE_B_WAKE_INT_EN 1
`define PWE_B_WAKE_INT 1
`define PWE_B_PHY_INT 2
`define PWE_B_FLAG_FRAME 4
`define PWE_B_FLAG_ENERGY 5
`define PWE_B_FRAME_EN 9
`define PWE_B_PHY_RST 10
`define PWE_B_ENERGY_EN 14
`define PWE_B_WSG_EN 8
`define PWE_B_PME_FLAG 15
`define PWE_B_PHY_MASK 7
`define PWE_B_PHY_EDPD 0
`define PWE_PM_D0 2'h0
`define PWE_PM_D3 2'h3

// ==============================
// Controller register offsets
`define PWE_AX_CTRL 4'h0
`define PWE_AX_STATUS 4'h4
`define PWE_AX_XADDR 4'h8
`define PWE_AX_XDATA 4'hc
`define PWE_AX_XCMD 5'h10
`define PWE_AX_XRDATA 5'h14
`define PWE_AX_OKAY 2'h0
`define PWE_AX_SLVERR 2'h2

`endif

// *** core/pwe_pkg.sv ***
package pwe_pkg;
  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_HALT, SEQ_PHY, SEQ_CLR, SEQ_EN, SEQ_PME, SEQ_D3, SEQ_DIRECT, SEQ_WAIT
  } pwe_seq_t;
  typedef logic [7:0] pwe_addr_t;
  typedef logic [31:0] pwe_word_t;
endpackage : pwe_pkg

// *** core/pwe_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pwe_if (input wire logic mclk);
  import pwe_pkg::*;
  // Register access, one request per ack
  logic reg_req;
  logic reg_we;
  pwe_addr_t reg_addr;
  pwe_word_t reg_wdata;
  pwe_word_t reg_rdata;
  logic reg_ack;
  // Power-management wake, active low
  logic wake_request_out_n;

  modport dev (
    input reg_req, reg_we, reg_addr, reg_wdata,
    output reg_rdata, reg_ack, wake_request_out_n
  );
  modport host (
    output reg_req, reg_we, reg_addr, reg_wdata,
    input reg_rdata, reg_ack, wake_request_out_n
  );
endinterface : pwe_if
`default_nettype wire

// *** core/pwe_device.sv ***
// Functional notes
// - Host drains traffic and halts DMA first
// - Enable with frame flag set wakes immediately
// - Frame flag clear blocked while MAC event
// - Wake enable must precede D3 entry
// - Power state D3 code enters D3hot
// - Armed frame detection asserts wake output
// - Wake output holds until enable/flag cleared
// - Wake-caused device reset clears frame flag
// - Host unmasks PHY energy interrupt bit 7
// - Energy-detect powerdown: no traffic, activity interrupt
// - Enable with energy flag set wakes immediately
// - Energy flag clear blocked while PHY interrupt
// - D3 without wake enable powers PHY down
// - Armed energy detection asserts wake output
// - Write one clears, zero leaves bit
// - Self-clearing bits return to zero, readable
// - Soft-reset-immune bits keep value
// - Soft irq enable rising edge sets interrupt
// - Enabled sources raise internal wake event
// - Wake status clears once both flags clear
`timescale 1ns/1ps
`default_nettype none
`include "pwe_regs.svh"
module pwe_device
  import pwe_pkg::*;
(
  // Clock and resets
  input wire logic mclk,
  input wire logic srst,
  input wire logic soft_rst,
  input wire logic wake_reset,
  // Host side
  pwe_if.dev bus,
  // MAC and PHY events
  input wire logic mac_wake_event,
  input wire logic phy_energy_in,
  // PHY control and state
  output logic phy_powerdown,
  output logic phy_edpd_mode,
  output logic phy_reset_pulse,
  output logic in_d3,
  output logic wake_int
);

  // ==============================
  // Register state
  logic soft_irq_trigger_r;
  logic wake_int_en_r;
  logic soft_irq_flag_r;
  logic [1:0] wakeup_source_flags_r;
  logic frame_wake_enable_r;
  logic energy_wake_enable_r;
  logic phy_rst_r;
  logic [1:0] power_state_field_r;
  logic wake_signal_enable_r;
  logic wake_signal_flag_r;
  logic phy_mask_r;
  logic phy_edpd_r;
  logic gpd_r;
  pwe_word_t rdata_r;
  logic ack_r;

  logic wr;
  logic rd;
  logic wr_ctl;
  logic wr_sts;
  logic wr_pm;
  logic wr_pmcsr;
  logic wr_phy;
  logic phy_irq;
  logic wake_event;
  logic d3_entry;
  logic detect_ok;
  pwe_word_t rd_word;

  assign wr = bus.reg_req && bus.reg_we;
  assign rd = bus.reg_req && !bus.reg_we;
  assign wr_ctl = wr && bus.reg_addr == `PWE_OFF_INT_EN_CTL;
  assign wr_sts = wr && bus.reg_addr == `PWE_OFF_IRQ_STS;
  assign wr_pm = wr && bus.reg_addr == `PWE_OFF_PM_CTL;
  assign wr_pmcsr = wr && bus.reg_addr == `PWE_OFF_PCI_PMCTL;
  assign wr_phy = wr && bus.reg_addr == `PWE_OFF_PHY_CFG;

  // PHY raises its interrupt only for an unmasked energy event
  assign phy_irq = phy_energy_in && phy_mask_r;
  // Level-based so a flag already set fires as soon as its enable rises
  assign wake_event = (frame_wake_enable_r && wakeup_source_flags_r[1])
    || (energy_wake_enable_r && wakeup_source_flags_r[0]);
  assign d3_entry = wr_pmcsr && bus.reg_wdata[1:0] == `PWE_PM_D3 && power_state_field_r != `PWE_PM_D3;
  // Powered-down PHY sees no frames and no line energy
  assign detect_ok = !gpd_r;

  // ==============================
  // Interrupt enable control
  always_ff @(posedge mclk) begin
    if (srst || soft_rst || wake_reset) begin
      soft_irq_trigger_r <= 1'b0;
      wake_int_en_r <= 1'b0;
    end else if (wr_ctl) begin
      soft_irq_trigger_r <= bus.reg_wdata[`PWE_B_SOFT_IRQ];
      wake_int_en_r <= bus.reg_wdata[`PWE_B_WAKE_INT_EN];
    end
  end

  // Soft interrupt flag: a fresh rising edge beats a same-cycle clear
  always_ff @(posedge mclk) begin
    if (srst || soft_rst || wake_reset) begin
      soft_irq_flag_r <= 1'b0;
    end else if (wr_ctl && bus.reg_wdata[`PWE_B_SOFT_IRQ] && !soft_irq_trigger_r) begin
      soft_irq_flag_r <= 1'b1;
    end else if (wr_sts && bus.reg_wdata[`PWE_B_SOFT_IRQ]) begin
      soft_irq_flag_r <= 1'b0;
    end
  end

  // ==============================
  // Wakeup source flags, kept across software reset
  generate
    for (genvar i = 0; i < 2; i++) begin : g_flag
      logic src;
      logic clr;
      assign src = detect_ok && (i == 1 ? mac_wake_event : phy_irq);
      assign clr = wr_pm && bus.reg_wdata[i == 1 ? `PWE_B_FLAG_FRAME : `PWE_B_FLAG_ENERGY];
      always_ff @(posedge mclk) begin
        if (srst) begin
          wakeup_source_flags_r[i] <= 1'b0;
        end else if (src) begin
          // Source still active holds the flag against any clear
          wakeup_source_flags_r[i] <= 1'b1;
        end else if (clr || (i == 1 && wake_reset)) begin
          wakeup_source_flags_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Wake enables survive software reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      frame_wake_enable_r <= 1'b0;
      energy_wake_enable_r <= 1'b0;
    end else if (wr_pm) begin
      frame_wake_enable_r <= bus.reg_wdata[`PWE_B_FRAME_EN];
      energy_wake_enable_r <= bus.reg_wdata[`PWE_B_ENERGY_EN];
    end
  end

  // PHY reset bit clears itself one cycle after it is written
  always_ff @(posedge mclk) begin
    if (srst || soft_rst) begin
      phy_rst_r <= 1'b0;
    end else begin
      phy_rst_r <= wr_pm && bus.reg_wdata[`PWE_B_PHY_RST];
    end
  end

  // ==============================
  // PCI power state and wake signal context
  always_ff @(posedge mclk) begin
    if (srst) begin
      power_state_field_r <= `PWE_PM_D0;
      wake_signal_enable_r <= 1'b0;
    end else if (wr_pmcsr) begin
      power_state_field_r <= bus.reg_wdata[1:0];
      wake_signal_enable_r <= bus.reg_wdata[`PWE_B_WSG_EN];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wake_signal_flag_r <= 1'b0;
    end else if (wake_event && wake_signal_enable_r && detect_ok) begin
      wake_signal_flag_r <= 1'b1;
    end else if (wr_pmcsr && bus.reg_wdata[`PWE_B_PME_FLAG]) begin
      wake_signal_flag_r <= 1'b0;
    end
  end

  // Enable is sampled only at D3 entry; leaving D3 restores the PHY
  always_ff @(posedge mclk) begin
    if (srst) begin
      gpd_r <= 1'b0;
    end else if (d3_entry) begin
      gpd_r <= !wake_signal_enable_r;
    end else if (wr_pmcsr && bus.reg_wdata[1:0] != `PWE_PM_D3) begin
      gpd_r <= 1'b0;
    end
  end

  // ==============================
  // PHY configuration
  always_ff @(posedge mclk) begin
    if (srst) begin
      phy_mask_r <= 1'b0;
      phy_edpd_r <= 1'b0;
    end else if (wr_phy) begin
      phy_mask_r <= bus.reg_wdata[`PWE_B_PHY_MASK];
      phy_edpd_r <= bus.reg_wdata[`PWE_B_PHY_EDPD];
    end
  end

  // ==============================
  // Read mux and acknowledge
  always_comb begin
    rd_word = '0;
    unique case (bus.reg_addr)
      `PWE_OFF_INT_EN_CTL: begin
        rd_word[`PWE_B_SOFT_IRQ] = soft_irq_trigger_r;
        rd_word[`PWE_B_WAKE_INT_EN] = wake_int_en_r;
      end
      `PWE_OFF_IRQ_STS: begin
        rd_word[`PWE_B_SOFT_IRQ] = soft_irq_flag_r;
        rd_word[`PWE_B_PHY_INT] = phy_irq;
        rd_word[`PWE_B_WAKE_INT] = |wakeup_source_flags_r;
      end
      `PWE_OFF_PM_CTL: begin
        rd_word[`PWE_B_FLAG_FRAME] = wakeup_source_flags_r[1];
        rd_word[`PWE_B_FLAG_ENERGY] = wakeup_source_flags_r[0];
        rd_word[`PWE_B_FRAME_EN] = frame_wake_enable_r;
        rd_word[`PWE_B_PHY_RST] = phy_rst_r;
        rd_word[`PWE_B_ENERGY_EN] = energy_wake_enable_r;
      end
      `PWE_OFF_PCI_PMCTL: begin
        rd_word[1:0] = power_state_field_r;
        rd_word[`PWE_B_WSG_EN] = wake_signal_enable_r;
        rd_word[`PWE_B_PME_FLAG] = wake_signal_flag_r;
      end
      `PWE_OFF_PHY_CFG: begin
        rd_word[`PWE_B_PHY_MASK] = phy_mask_r;
        rd_word[`PWE_B_PHY_EDPD] = phy_edpd_r;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_r <= '0;
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus.reg_req;
      if (rd) begin
        rdata_r <= rd_word;
      end
    end
  end

  // ==============================
  // Outputs
  assign bus.reg_ack = ack_r;
  assign bus.reg_rdata = rdata_r;
  assign bus.wake_request_out_n = !(wake_signal_enable_r && wake_signal_flag_r);
  assign phy_powerdown = gpd_r;
  assign phy_edpd_mode = phy_edpd_r;
  assign phy_reset_pulse = phy_rst_r;
  assign in_d3 = power_state_field_r == `PWE_PM_D3;
  assign wake_int = |wakeup_source_flags_r && wake_int_en_r;

endmodule : pwe_device
`default_nettype wire

// *** core/pwe_host.sv ***
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pwe_regs.svh"
module pwe_host
  import pwe_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // AXI4-Lite slave
  input wire logic [4:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [4:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Traffic quiesce handshake
  output logic halt_req,
  input wire logic dma_idle,
  // Device side
  pwe_if.host dev
);

  // ==============================
  // Controller registers
  logic arm_frame_r;
  logic arm_energy_r;
  logic arm_d3_r;
  logic done_r;
  pwe_addr_t xaddr_r;
  pwe_word_t xdata_r;
  pwe_word_t xrdata_r;
  logic aw_got_r;
  logic w_got_r;
  logic [4:0] aw_r;
  pwe_word_t w_r;
  logic go_arm;
  logic go_x;
  logic x_we;
  logic wr_fire;
  pwe_seq_t seq_r;
  pwe_seq_t after_r;
  logic req_r;
  logic we_r;
  pwe_addr_t addr_r;
  pwe_word_t wd_r;

  // Address and data may arrive in either order
  assign s_awready = !aw_got_r && !s_bvalid;
  assign s_wready = !w_got_r && !s_bvalid;
  assign wr_fire = aw_got_r && w_got_r && !s_bvalid;
  assign go_arm = wr_fire && aw_r == {1'b0, `PWE_AX_CTRL} && w_r[0] && seq_r == SEQ_IDLE;
  assign go_x = wr_fire && aw_r == `PWE_AX_XCMD && w_r[0] && seq_r == SEQ_IDLE;
  assign x_we = w_r[1];

  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= '0;
      w_r <= '0;
      s_bvalid <= 1'b0;
      s_bresp <= `PWE_AX_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got_r <= 1'b1;
        aw_r <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_got_r <= 1'b1;
        w_r <= s_wdata;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (aw_r[1:0] != 2'h0 || aw_r > `PWE_AX_XRDATA) ? `PWE_AX_SLVERR : `PWE_AX_OKAY;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Full words only; strobes are accepted but not split
  always_ff @(posedge mclk) begin
    if (srst) begin
      arm_frame_r <= 1'b0;
      arm_energy_r <= 1'b0;
      arm_d3_r <= 1'b0;
      xaddr_r <= '0;
      xdata_r <= '0;
    end else if (wr_fire && s_wstrb != 4'h0) begin
      if (aw_r == {1'b0, `PWE_AX_CTRL}) begin
        arm_frame_r <= w_r[1];
        arm_energy_r <= w_r[2];
        arm_d3_r <= w_r[3];
      end
      if (aw_r == {1'b0, `PWE_AX_XADDR}) begin
        xaddr_r <= w_r[7:0];
      end
      if (aw_r == {1'b0, `PWE_AX_XDATA}) begin
        xdata_r <= w_r;
      end
    end
  end

  // ==============================
  // Read channel
  assign s_arready = !s_rvalid;
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= `PWE_AX_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp <= `PWE_AX_OKAY;
      s_rdata <= '0;
      unique case (s_araddr)
        {1'b0, `PWE_AX_CTRL}: s_rdata <= {28'h0, arm_d3_r, arm_energy_r, arm_frame_r, 1'b0};
        {1'b0, `PWE_AX_STATUS}: s_rdata <= {29'h0, !dev.wake_request_out_n, done_r, seq_r != SEQ_IDLE};
        {1'b0, `PWE_AX_XADDR}: s_rdata <= {24'h0, xaddr_r};
        {1'b0, `PWE_AX_XDATA}: s_rdata <= xdata_r;
        `PWE_AX_XCMD: s_rdata <= '0;
        `PWE_AX_XRDATA: s_rdata <= xrdata_r;
        default: s_rresp <= `PWE_AX_SLVERR;
      endcase
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ==============================
  // Arming sequencer: each step from SEQ_HALT to SEQ_PME is one device access; SEQ_D3 and SEQ_DIRECT make none
  always_ff @(posedge mclk) begin
    if (srst) begin
      seq_r <= SEQ_IDLE;
      after_r <= SEQ_IDLE;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= '0;
      wd_r <= '0;
      done_r <= 1'b0;
      halt_req <= 1'b0;
      xrdata_r <= '0;
    end else begin
      req_r <= 1'b0;
      unique case (seq_r)
        SEQ_IDLE: begin
          if (go_arm) begin
            done_r <= 1'b0;
            halt_req <= 1'b1;
            seq_r <= SEQ_HALT;
          end else if (go_x) begin
            done_r <= 1'b0;
            req_r <= 1'b1;
            we_r <= x_we;
            addr_r <= xaddr_r;
            wd_r <= xdata_r;
            after_r <= SEQ_DIRECT;
            seq_r <= SEQ_WAIT;
          end
        end
        // Wake sources are touched only once all DMA work is over
        SEQ_HALT: if (dma_idle) begin
          req_r <= 1'b1;
          we_r <= 1'b1;
          addr_r <= `PWE_OFF_PHY_CFG;
          wd_r <= '0;
          wd_r[`PWE_B_PHY_MASK] <= arm_energy_r;
          wd_r[`PWE_B_PHY_EDPD] <= arm_energy_r;
          after_r <= SEQ_PHY;
          seq_r <= SEQ_WAIT;
        end
        SEQ_PHY: begin
          // Flags cleared before enables so stale events do not wake
          req_r <= 1'b1;
          addr_r <= `PWE_OFF_PM_CTL;
          wd_r <= '0;
          wd_r[`PWE_B_FLAG_FRAME] <= 1'b1;
          wd_r[`PWE_B_FLAG_ENERGY] <= 1'b1;
          after_r <= SEQ_CLR;
          seq_r <= SEQ_WAIT;
        end
        SEQ_CLR: begin
          req_r <= 1'b1;
          wd_r <= '0;
          wd_r[`PWE_B_FRAME_EN] <= arm_frame_r;
          wd_r[`PWE_B_ENERGY_EN] <= arm_energy_r;
          after_r <= SEQ_EN;
          seq_r <= SEQ_WAIT;
        end
        SEQ_EN: begin
          req_r <= 1'b1;
          addr_r <= `PWE_OFF_PCI_PMCTL;
          wd_r <= '0;
          wd_r[`PWE_B_WSG_EN] <= 1'b1;
          after_r <= arm_d3_r ? SEQ_PME : SEQ_D3;
          seq_r <= SEQ_WAIT;
        end
        SEQ_PME: begin
          req_r <= 1'b1;
          wd_r[1:0] <= `PWE_PM_D3;
          after_r <= SEQ_D3;
          seq_r <= SEQ_WAIT;
        end
        SEQ_D3: begin
          halt_req <= 1'b0;
          done_r <= 1'b1;
          seq_r <= SEQ_IDLE;
        end
        SEQ_DIRECT: begin
          done_r <= 1'b1;
          seq_r <= SEQ_IDLE;
        end
        SEQ_WAIT: if (dev.reg_ack) begin
          if (!we_r) begin
            xrdata_r <= dev.reg_rdata;
          end
          we_r <= 1'b1;
          seq_r <= after_r;
        end
        default: seq_r <= SEQ_IDLE;
      endcase
    end
  end

  assign dev.reg_req = req_r;
  assign dev.reg_we = we_r;
  assign dev.reg_addr = addr_r;
  assign dev.reg_wdata = wd_r;

endmodule : pwe_host
`default_nettype wire

// *** bench/pwe_checker_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwe_regs.svh"
module pwe_checker
  import pwe_pkg::*;
(
  // Clock and resets
  input wire logic mclk,
  input wire logic srst,
  input wire logic soft_rst,
  input wire logic wake_reset,
  // Register port
  input wire logic reg_req,
  input wire logic reg_we,
  input wire pwe_addr_t reg_addr,
  input wire pwe_word_t reg_wdata,
  input wire pwe_word_t reg_rdata,
  input wire logic reg_ack,
  // Wake output
  input wire logic wake_request_out_n
);
  // ==========================================
  // Shadow state rebuilt from observed writes
  logic wr;
  logic rd;
  logic wsg_en_r;
  logic trig_r;
  logic wint_en_r;
  logic soft_flag_r;

  assign wr = reg_req && reg_we;
  assign rd = reg_req && !reg_we;

  // Power control survives soft and wake resets
  always_ff @(posedge mclk) begin
    if (srst) begin
      wsg_en_r <= 1'b0;
    end else if (wr && reg_addr == `PWE_OFF_PCI_PMCTL) begin
      wsg_en_r <= reg_wdata[`PWE_B_WSG_EN];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || soft_rst || wake_reset) begin
      trig_r <= 1'b0;
      wint_en_r <= 1'b0;
      soft_flag_r <= 1'b0;
    end else if (wr && reg_addr == `PWE_OFF_INT_EN_CTL) begin
      trig_r <= reg_wdata[`PWE_B_SOFT_IRQ];
      wint_en_r <= reg_wdata[`PWE_B_WAKE_INT_EN];
      if (reg_wdata[`PWE_B_SOFT_IRQ] && !trig_r) begin
        soft_flag_r <= 1'b1;
      end
    end else if (wr && reg_addr == `PWE_OFF_IRQ_STS && reg_wdata[`PWE_B_SOFT_IRQ]) begin
      soft_flag_r <= 1'b0;
    end
  end

  // ==========================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_ack_after_req; reg_req |=> reg_ack; endproperty
  a_ack_after_req: assert property (p_ack_after_req)
    else $error("register request not acknowledged next cycle");

  property p_ack_has_req; reg_ack |-> $past(reg_req); endproperty
  a_ack_has_req: assert property (p_ack_has_req)
    else $error("acknowledge without a request");

  property p_unmapped_zero;
    rd && !(reg_addr inside {`PWE_OFF_INT_EN_CTL, `PWE_OFF_IRQ_STS, `PWE_OFF_PM_CTL, `PWE_OFF_PCI_PMCTL,
      `PWE_OFF_PHY_CFG}) |=> reg_ack && reg_rdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned nonzero data");

  property p_wake_needs_pme; !wake_request_out_n |-> wsg_en_r; endproperty
  a_wake_needs_pme: assert property (p_wake_needs_pme)
    else $error("wake output active without wake signal enable");

  property p_wake_release;
    $rose(wake_request_out_n) |-> $past(wr && reg_addr == `PWE_OFF_PCI_PMCTL);
  endproperty
  a_wake_release: assert property (p_wake_release)
    else $error("wake output released without a host clear");

  property p_pme_off_release;
    wr && reg_addr == `PWE_OFF_PCI_PMCTL && !reg_wdata[`PWE_B_WSG_EN] |=> wake_request_out_n;
  endproperty
  a_pme_off_release: assert property (p_pme_off_release)
    else $error("wake output still active after enable cleared");

  property p_phy_rst_selfclr;
    rd && reg_addr == `PWE_OFF_PM_CTL && !$past(wr && reg_addr == `PWE_OFF_PM_CTL) |=> !reg_rdata[`PWE_B_PHY_RST];
  endproperty
  a_phy_rst_selfclr: assert property (p_phy_rst_selfclr)
    else $error("phy reset bit did not clear itself");

  property p_soft_irq_flag;
    rd && reg_addr == `PWE_OFF_IRQ_STS |=> reg_rdata[`PWE_B_SOFT_IRQ] == soft_flag_r;
  endproperty
  a_soft_irq_flag: assert property (p_soft_irq_flag)
    else $error("software interrupt flag read back wrong");

  property p_interrupt_enable_control_value;
    rd && reg_addr == `PWE_OFF_INT_EN_CTL |=> reg_rdata[`PWE_B_SOFT_IRQ] == trig_r
      && reg_rdata[`PWE_B_WAKE_INT_EN] == wint_en_r;
  endproperty
  a_interrupt_enable_control_value: assert property (p_interrupt_enable_control_value)
    else $error("interrupt control read back wrong");
endmodule : pwe_checker
`default_nettype wire

// *** bench/pci_wake_event_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwe_regs.svh"
module pci_wake_event_control_tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic soft_rst = 1'b0, wake_reset = 1'b0, mac_wake_event = 1'b0, phy_energy_in = 1'b0, dma_idle = 1'b0;
  logic [4:0] s_awaddr = 5'h00, s_araddr = 5'h00;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, br;
  logic [31:0] s_rdata, rv, st;
  logic halt_req, phy_powerdown, phy_edpd_mode, in_d3;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  always #5 mclk = ~mclk;

  pwe_if pwe_if_inst (.mclk(mclk));
  pwe_device pwe_device_inst (.mclk(mclk), .srst(srst), .soft_rst(soft_rst), .wake_reset(wake_reset),
    .bus(pwe_if_inst), .mac_wake_event(mac_wake_event), .phy_energy_in(phy_energy_in),
    .phy_powerdown(phy_powerdown), .phy_edpd_mode(phy_edpd_mode), .phy_reset_pulse(), .in_d3(in_d3),
    .wake_int());
  pwe_host pwe_host_inst (.mclk(mclk), .srst(srst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .halt_req(halt_req), .dma_idle(dma_idle), .dev(pwe_if_inst));
  pwe_checker pwe_checker_inst (.mclk(mclk), .srst(srst), .soft_rst(soft_rst), .wake_reset(wake_reset),
    .reg_req(pwe_if_inst.reg_req), .reg_we(pwe_if_inst.reg_we), .reg_addr(pwe_if_inst.reg_addr),
    .reg_wdata(pwe_if_inst.reg_wdata), .reg_rdata(pwe_if_inst.reg_rdata), .reg_ack(pwe_if_inst.reg_ack),
    .wake_request_out_n(pwe_if_inst.wake_request_out_n));

  // ==========================================
  // Checking and bus tasks
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task end_of_test();
    $display("Compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task axi_wr(input logic [4:0] a, input logic [31:0] d);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    br = s_bresp;
    s_bready <= 1'b0;
    @(posedge mclk);
  endtask : axi_wr

  task axi_rd(input logic [4:0] a, output logic [31:0] d);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    s_rready <= 1'b0;
    @(posedge mclk);
  endtask : axi_rd

  task host_idle();
    do axi_rd(`PWE_AX_STATUS, st); while (st[0] !== 1'b0);
  endtask : host_idle

  task dev_wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(`PWE_AX_XADDR, {24'h0, a});
    axi_wr(`PWE_AX_XDATA, d);
    axi_wr(`PWE_AX_XCMD, 32'h3);
    host_idle();
  endtask : dev_wr

  task dev_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    axi_wr(`PWE_AX_XADDR, {24'h0, a});
    axi_wr(`PWE_AX_XCMD, 32'h1);
    host_idle();
    axi_rd(`PWE_AX_XRDATA, rv);
    chk(nm, rv & m, e);
  endtask : dev_rd

  // Polls briefly because the wake flag lands a cycle after its cause
  task wait_wake(input logic exp);
    int n;
    n = 0;
    while (pwe_if_inst.wake_request_out_n !== exp && n < 50) begin
      @(posedge mclk);
      n++;
    end
    chk("wake_n", {31'h0, pwe_if_inst.wake_request_out_n}, {31'h0, exp});
  endtask : wait_wake

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================
  // Scenarios
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    dev_wr(`PWE_OFF_INT_EN_CTL, 32'h8002);
    dev_rd(`PWE_OFF_IRQ_STS, 32'h8000, 32'h8000, "soft_irq_set");
    dev_wr(`PWE_OFF_IRQ_STS, 32'h0);
    dev_rd(`PWE_OFF_IRQ_STS, 32'h8000, 32'h8000, "w1c_zero");
    dev_wr(`PWE_OFF_IRQ_STS, 32'h8000);
    dev_rd(`PWE_OFF_IRQ_STS, 32'h8000, 32'h0, "w1c_one");
    dev_wr(`PWE_OFF_INT_EN_CTL, 32'h8002);
    dev_rd(`PWE_OFF_IRQ_STS, 32'h8000, 32'h0, "no_edge");
    dev_wr(`PWE_OFF_PM_CTL, 32'h0400);
    dev_rd(`PWE_OFF_PM_CTL, 32'h0400, 32'h0, "phy_rst_sc");
    dev_wr(`PWE_OFF_PCI_PMCTL, 32'h0100);
    @(posedge mclk) soft_rst <= 1'b1;
    @(posedge mclk) soft_rst <= 1'b0;
    dev_rd(`PWE_OFF_INT_EN_CTL, 32'h8002, 32'h0, "ctl_soft");
    dev_rd(`PWE_OFF_PCI_PMCTL, 32'h0100, 32'h0100, "pme_keep");
    dev_rd(8'h70, 32'hffffffff, 32'h0, "unmapped");
    axi_wr(5'h18, 32'h0);
    chk("axi_bad", {30'h0, br}, {30'h0, `PWE_AX_SLVERR});
    // Energy arm with D3 entry; the host must stall until traffic is quiet
    axi_wr(`PWE_AX_CTRL, 32'hd);
    while (halt_req !== 1'b1) @(posedge mclk);
    axi_rd(`PWE_AX_STATUS, st);
    chk("arm_stall", st & 32'h3, 32'h1);
    dma_idle <= 1'b1;
    host_idle();
    dma_idle <= 1'b0;
    chk("d3", {31'h0, in_d3}, 32'h1);
    chk("pd_off", {31'h0, phy_powerdown}, 32'h0);
    chk("edpd", {31'h0, phy_edpd_mode}, 32'h1);
    dev_rd(`PWE_OFF_PHY_CFG, 32'h81, 32'h81, "phy_cfg");
    wait_wake(1'b1);
    phy_energy_in <= 1'b1;
    wait_wake(1'b0);
    axi_rd(`PWE_AX_STATUS, st);
    chk("st_wake", st & 32'h4, 32'h4);
    dev_wr(`PWE_OFF_PM_CTL, 32'h4020);
    dev_rd(`PWE_OFF_PM_CTL, 32'h0020, 32'h0020, "en_hold");
    dev_rd(`PWE_OFF_IRQ_STS, 32'h2, 32'h2, "wint_on");
    phy_energy_in <= 1'b0;
    dev_wr(`PWE_OFF_PM_CTL, 32'h4020);
    dev_rd(`PWE_OFF_PM_CTL, 32'h0020, 32'h0, "en_clr");
    dev_rd(`PWE_OFF_IRQ_STS, 32'h2, 32'h0, "wint_off");
    wait_wake(1'b0);
    dev_wr(`PWE_OFF_PCI_PMCTL, 32'h8103);
    wait_wake(1'b1);
    dev_wr(`PWE_OFF_PM_CTL, 32'h0);
    @(posedge mclk) phy_energy_in <= 1'b1;
    repeat (2) @(posedge mclk);
    phy_energy_in <= 1'b0;
    repeat (4) @(posedge mclk);
    wait_wake(1'b1);
    dev_wr(`PWE_OFF_PM_CTL, 32'h4000);
    wait_wake(1'b0);
    dev_wr(`PWE_OFF_PM_CTL, 32'h0020);
    dev_wr(`PWE_OFF_PCI_PMCTL, 32'h8100);
    wait_wake(1'b1);
    // Frame source: flag held while the MAC event stands
    mac_wake_event <= 1'b1;
    dev_wr(`PWE_OFF_PM_CTL, 32'h0010);
    dev_rd(`PWE_OFF_PM_CTL, 32'h0010, 32'h0010, "fr_hold");
    mac_wake_event <= 1'b0;
    wait_wake(1'b1);
    dev_wr(`PWE_OFF_PM_CTL, 32'h0200);
    wait_wake(1'b0);
    dev_wr(`PWE_OFF_PCI_PMCTL, 32'h0);
    wait_wake(1'b1);
    @(posedge mclk) wake_reset <= 1'b1;
    @(posedge mclk) wake_reset <= 1'b0;
    dev_rd(`PWE_OFF_PM_CTL, 32'h0010, 32'h0, "wake_rst");
    // D3 without wake enable: PHY powered down, no detection
    dev_wr(`PWE_OFF_PCI_PMCTL, 32'h3);
    chk("pd_on", {31'h0, phy_powerdown}, 32'h1);
    mac_wake_event <= 1'b1;
    phy_energy_in <= 1'b1;
    dev_rd(`PWE_OFF_PM_CTL, 32'h0030, 32'h0, "pd_blind");
    mac_wake_event <= 1'b0;
    phy_energy_in <= 1'b0;
    wait_wake(1'b1);
    dev_wr(`PWE_OFF_PCI_PMCTL, 32'h0);
    chk("pd_exit", {31'h0, phy_powerdown}, 32'h0);
    end_of_test();
  end
endmodule : pci_wake_event_control_tb
`default_nettype wire
